// *** inc/smsr_pkg.sv ***
// How it works
// - Accept word only after exactly 32 clocks
// - Wrong length frame discarded, error flag set
// - Error flag mirrored into response status
// - No error when select toggles without clocks
// - Reading event register clears both flags
// - Power-up flag one after every reset
// - Reset restores defaults and frame state
// - Power-up flag mirrored into response status
// - CRC field low 16 bits, resets ones
// - CRC bit order kept LSB to MSB
// - Live supply, thermal status, upper bits zero
// - Bit 3 reads under-voltage now
// - Bit 2 reads over-voltage now
// - Bit 1 reads temperature warning now
// - Bit 0 reads temperature shutdown now
// - One comparator level bit per input
package smsr_pkg;

  localparam int FRAME_BITS = 32;
  localparam int HEAD_BITS = 7;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam int CRC_W = 16;
  localparam int CNT_W = 6;
  localparam int NUM_INPUTS = 24;

  localparam logic [CNT_W-1:0] FRAME_LEN = 6'h20;
  localparam logic [CNT_W-1:0] HEAD_LEN = 6'h07;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;

  // Frame layout, first bit on the wire is bit 31
  localparam int CMD_POS = 31;
  localparam int ADDR_LSB = 25;
  localparam logic CMD_READ = 1'b0;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_EVENT = 6'h01;
  localparam logic [ADDR_W-1:0] OFS_CRC = 6'h03;
  localparam logic [ADDR_W-1:0] OFS_MISC = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_COMP = 6'h05;

  // Reset values
  localparam logic [CRC_W-1:0] CRC_RESET = 16'hFFFF;
  localparam logic [NUM_INPUTS-1:0] COMP_RESET = 24'h000000;

  // Event register and response header bit positions
  localparam int EVT_FRAME_POS = 1;
  localparam int EVT_POR_POS = 0;
  localparam int HDR_POR_POS = 6;
  localparam int HDR_FRAME_POS = 5;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } smsr_spi_pins_s;

  // Mode 0: deselected with the serial clock low
  localparam smsr_spi_pins_s SPI_IDLE = 3'h4;

  typedef struct packed {
    logic low_supply_now;
    logic high_supply_now;
    logic hot_warning_now;
    logic overheat_now;
  } smsr_live_s;

  localparam smsr_live_s LIVE_RESET = 4'h0;

  typedef enum logic [3:0] {
    SMSR_IDLE = 4'h1,
    SMSR_HEAD = 4'h2,
    SMSR_DATA = 4'h4,
    SMSR_OVER = 4'h8
  } smsr_state_e;

endpackage : smsr_pkg

// *** core/smsr_sync.sv ***
`timescale 1ns/1ns
module smsr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] mid_q;
  logic [WIDTH-1:0] late_q;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= RESET_VAL;
      mid_q <= RESET_VAL;
      late_q <= RESET_VAL;
    end else begin
      meta_q <= d_i;
      mid_q <= meta_q;
      late_q <= mid_q;
    end
  end

  // A change only counts once two stages agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        q_o[i] <= RESET_VAL[i];
      end else if (mid_q[i] == late_q[i]) begin
        q_o[i] <= late_q[i];
      end
    end
  end

endmodule : smsr_sync

// *** core/smsr_frame_counter.sv ***
`timescale 1ns/1ns
module smsr_frame_counter (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic restart_i,
  // Filtered pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  // Events
  output logic sclk_rise_o,
  output logic sclk_fall_o,
  output logic frame_start_o,
  output logic frame_end_o,
  // Count
  output logic [smsr_pkg::CNT_W-1:0] bit_count_o,
  output logic length_ok_o,
  output logic had_edges_o
);

  logic cs_n_q;
  logic sclk_q;
  logic [smsr_pkg::CNT_W-1:0] count_q;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      cs_n_q <= cs_n_i;
      sclk_q <= sclk_i;
    end
  end

  assign frame_start_o = cs_n_q && !cs_n_i;
  assign frame_end_o = !cs_n_q && cs_n_i;
  assign sclk_rise_o = !cs_n_i && !sclk_q && sclk_i;
  assign sclk_fall_o = !cs_n_i && sclk_q && !sclk_i;

  // Saturates so a very long frame never wraps back to a legal count
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_q <= '0;
    end else if (restart_i || frame_start_o) begin
      count_q <= '0;
    end else if (sclk_rise_o && count_q != smsr_pkg::CNT_MAX) begin
      count_q <= count_q + 6'h01;
    end
  end

  assign bit_count_o = count_q;
  assign length_ok_o = count_q == smsr_pkg::FRAME_LEN;
  assign had_edges_o = count_q != '0;

endmodule : smsr_frame_counter

// *** core/smsr_status_regs.sv ***
`timescale 1ns/1ns
module smsr_status_regs (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  // Serial pins
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  // CRC engine result
  input wire logic [smsr_pkg::CRC_W-1:0] crc_value_i,
  input wire logic crc_valid_i,
  // Live supply and thermal conditions
  input wire logic low_supply_now_i,
  input wire logic high_supply_now_i,
  input wire logic hot_warning_now_i,
  input wire logic overheat_now_i,
  // Comparator outputs, one per switch input
  input wire logic [smsr_pkg::NUM_INPUTS-1:0] comp_level_i,
  // Accepted frames
  output logic word_valid_o,
  output logic [smsr_pkg::FRAME_BITS-1:0] word_o,
  // Event flags
  output logic frame_err_flag_o,
  output logic por_flag_o
);

  smsr_pkg::smsr_spi_pins_s pins_raw;
  smsr_pkg::smsr_spi_pins_s pins;
  smsr_pkg::smsr_live_s live_raw;
  smsr_pkg::smsr_live_s live;
  logic [smsr_pkg::NUM_INPUTS-1:0] comp_sync;

  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  logic [smsr_pkg::CNT_W-1:0] bit_count;
  logic length_ok;
  logic had_edges;

  smsr_pkg::smsr_state_e state_q;
  smsr_pkg::smsr_state_e state_d;

  logic [smsr_pkg::FRAME_BITS-1:0] rx_q;
  logic [smsr_pkg::FRAME_BITS-1:0] rx_d;
  logic [smsr_pkg::FRAME_BITS-1:0] tx_q;
  logic [smsr_pkg::CRC_W-1:0] crc_q;
  logic [smsr_pkg::NUM_INPUTS-1:0] comp_q;
  smsr_pkg::smsr_live_s live_q;
  logic frame_err_q;
  logic por_q;
  logic word_valid_q;
  logic [smsr_pkg::FRAME_BITS-1:0] word_q;

  logic [smsr_pkg::ADDR_W-1:0] head_addr;
  logic [smsr_pkg::DATA_W-1:0] read_data;
  logic [smsr_pkg::HEAD_BITS-1:0] head_flags;
  logic head_done;
  logic frame_good;
  logic frame_bad;
  logic event_read;

  // Pins and analog flags come from outside the clock domain
  assign pins_raw = {spi_cs_n_i, spi_sclk_i, spi_mosi_i};
  assign live_raw = {low_supply_now_i, high_supply_now_i,
                     hot_warning_now_i, overheat_now_i};

  smsr_sync #(
    .WIDTH(3),
    .RESET_VAL(smsr_pkg::SPI_IDLE)
  ) u_pin_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  smsr_sync #(
    .WIDTH(4),
    .RESET_VAL(smsr_pkg::LIVE_RESET)
  ) u_live_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .d_i(live_raw),
    .q_o(live)
  );

  smsr_sync #(
    .WIDTH(smsr_pkg::NUM_INPUTS),
    .RESET_VAL(smsr_pkg::COMP_RESET)
  ) u_comp_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .d_i(comp_level_i),
    .q_o(comp_sync)
  );

  smsr_frame_counter u_counter (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .restart_i(soft_reset_i),
    .cs_n_i(pins.cs_n),
    .sclk_i(pins.sclk),
    .sclk_rise_o(sclk_rise),
    .sclk_fall_o(sclk_fall),
    .frame_start_o(frame_start),
    .frame_end_o(frame_end),
    .bit_count_o(bit_count),
    .length_ok_o(length_ok),
    .had_edges_o(had_edges)
  );

  // Frame sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      smsr_pkg::SMSR_IDLE: begin
        if (frame_start) begin
          state_d = smsr_pkg::SMSR_HEAD;
        end
      end
      smsr_pkg::SMSR_HEAD: begin
        if (frame_end) begin
          state_d = smsr_pkg::SMSR_IDLE;
        end else if (head_done) begin
          state_d = smsr_pkg::SMSR_DATA;
        end
      end
      smsr_pkg::SMSR_DATA: begin
        if (frame_end) begin
          state_d = smsr_pkg::SMSR_IDLE;
        end else if (sclk_rise
                     && bit_count == smsr_pkg::FRAME_LEN) begin
          state_d = smsr_pkg::SMSR_OVER;
        end
      end
      smsr_pkg::SMSR_OVER: begin
        if (frame_end) begin
          state_d = smsr_pkg::SMSR_IDLE;
        end
      end
      default: begin
        state_d = smsr_pkg::SMSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= smsr_pkg::SMSR_IDLE;
    end else if (soft_reset_i) begin
      state_q <= smsr_pkg::SMSR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Receive side
  assign rx_d = {rx_q[smsr_pkg::FRAME_BITS-2:0], pins.mosi};
  assign head_done = sclk_rise && state_q == smsr_pkg::SMSR_HEAD
                     && bit_count == smsr_pkg::HEAD_LEN - 6'h01;
  assign head_addr = rx_d[smsr_pkg::ADDR_W-1:0];

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_q <= '0;
    end else if (soft_reset_i || frame_start) begin
      rx_q <= '0;
    end else if (sclk_rise) begin
      rx_q <= rx_d;
    end
  end

  // Zero clock frames are ignored, not flagged
  assign frame_good = frame_end && length_ok;
  assign frame_bad = frame_end && !length_ok && had_edges;
  assign event_read = frame_good
                      && rx_q[smsr_pkg::CMD_POS] == smsr_pkg::CMD_READ
                      && rx_q[smsr_pkg::CMD_POS-1:smsr_pkg::ADDR_LSB]
                         == smsr_pkg::OFS_EVENT;

  // Bad frames never reach the word port
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      word_valid_q <= 1'b0;
      word_q <= '0;
    end else if (soft_reset_i) begin
      word_valid_q <= 1'b0;
      word_q <= '0;
    end else begin
      word_valid_q <= frame_good;
      if (frame_good) begin
        word_q <= rx_q;
      end
    end
  end

  // Event flags; a set in the clearing cycle still wins
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_err_q <= 1'b0;
    end else if (soft_reset_i) begin
      frame_err_q <= 1'b0;
    end else if (frame_bad) begin
      frame_err_q <= 1'b1;
    end else if (event_read) begin
      frame_err_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      por_q <= 1'b1;
    end else if (soft_reset_i) begin
      por_q <= 1'b1;
    end else if (event_read) begin
      por_q <= 1'b0;
    end
  end

  // Status registers follow hardware only; no frame writes them
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      crc_q <= smsr_pkg::CRC_RESET;
    end else if (soft_reset_i) begin
      crc_q <= smsr_pkg::CRC_RESET;
    end else if (crc_valid_i) begin
      crc_q <= crc_value_i;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      live_q <= smsr_pkg::LIVE_RESET;
      comp_q <= smsr_pkg::COMP_RESET;
    end else begin
      live_q <= live;
      comp_q <= comp_sync;
    end
  end

  // Read mux, unmapped offsets answer zero
  always_comb begin
    read_data = '0;
    case (head_addr)
      smsr_pkg::OFS_EVENT: begin
        read_data[smsr_pkg::EVT_FRAME_POS] = frame_err_q;
        read_data[smsr_pkg::EVT_POR_POS] = por_q;
      end
      smsr_pkg::OFS_CRC: begin
        read_data[smsr_pkg::CRC_W-1:0] = crc_q;
      end
      smsr_pkg::OFS_MISC: begin
        read_data[3] = live_q.low_supply_now;
        read_data[2] = live_q.high_supply_now;
        read_data[1] = live_q.hot_warning_now;
        read_data[0] = live_q.overheat_now;
      end
      smsr_pkg::OFS_COMP: begin
        read_data = comp_q;
      end
      default: begin
        read_data = '0;
      end
    endcase
  end

  // Status header leads every response
  always_comb begin
    head_flags = '0;
    head_flags[smsr_pkg::HDR_POR_POS] = por_q;
    head_flags[smsr_pkg::HDR_FRAME_POS] = frame_err_q;
  end

  // Transmit side; data is loaded before the eighth bit goes out
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_q <= '0;
    end else if (soft_reset_i) begin
      tx_q <= '0;
    end else if (frame_start) begin
      tx_q <= {head_flags, 25'h0000000};
    end else if (head_done) begin
      tx_q <= {tx_q[31], read_data, tx_q[6:0]};
    end else if (sclk_fall) begin
      tx_q <= {tx_q[smsr_pkg::FRAME_BITS-2:0], 1'b0};
    end
  end

  assign spi_miso_o = tx_q[smsr_pkg::FRAME_BITS-1];
  assign spi_miso_oe_o = !pins.cs_n;
  assign word_valid_o = word_valid_q;
  assign word_o = word_q;
  assign frame_err_flag_o = frame_err_q;
  assign por_flag_o = por_q;

endmodule : smsr_status_regs

// *** verif/smsr_host.sv ***
`timescale 1ns/1ns
module smsr_host (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Frame request
  input wire logic go_i,
  input wire logic [31:0] word_i,
  input wire logic [5:0] bits_i,
  output logic busy_o,
  output logic [31:0] resp_o,
  // Serial pins
  output smsr_pkg::smsr_spi_pins_s pins_o,
  input wire logic miso_i
);
  logic [31:0] sh_q;
  logic [5:0] left_q;
  logic [2:0] ph_q;

  // Half period of 8 clocks leaves room for the synchronisers
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
      resp_o <= 32'h0;
      pins_o <= smsr_pkg::SPI_IDLE;
      sh_q <= 32'h0;
      left_q <= 6'h00;
      ph_q <= 3'h0;
    end else if (!busy_o) begin
      if (go_i) begin
        busy_o <= 1'b1;
        pins_o <= {2'b00, word_i[31]};
        sh_q <= word_i << 1;
        left_q <= bits_i;
        ph_q <= 3'h0;
      end else begin
        // Released data line never shows a stable old value
        pins_o.mosi <= ~pins_o.mosi;
      end
    end else begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7 && left_q == 6'h00) begin
        pins_o.cs_n <= 1'b1;
        busy_o <= 1'b0;
      end else if (ph_q == 3'h7 && !pins_o.sclk) begin
        pins_o.sclk <= 1'b1;
        resp_o <= {resp_o[30:0], miso_i};
      end else if (ph_q == 3'h7) begin
        pins_o.sclk <= 1'b0;
        pins_o.mosi <= sh_q[31];
        sh_q <= sh_q << 1;
        left_q <= left_q - 6'h01;
      end
    end
  end
endmodule : smsr_host

// *** verif/smsr_status_regs_chk.sv ***
`timescale 1ns/1ns
module smsr_status_regs_chk (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  // Watched ports
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o,
  input wire logic word_valid_o,
  input wire logic [smsr_pkg::FRAME_BITS-1:0] word_o,
  input wire logic frame_err_flag_o,
  input wire logic por_flag_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_quiet_start;
    $fell(spi_cs_n_i) ##1 (!spi_cs_n_i && !spi_sclk_i) [*7];
  endsequence
  sequence s_cs_idle;
    spi_cs_n_i [*6];
  endsequence
  sequence s_cs_active;
    (!spi_cs_n_i) [*6];
  endsequence
  sequence s_event_read;
    word_valid_o && word_o[31:25] == {smsr_pkg::CMD_READ, smsr_pkg::OFS_EVENT};
  endsequence

  property p_header;
    s_quiet_start |-> spi_miso_o == por_flag_o;
  endproperty
  property p_wv_pulse;
    word_valid_o |=> !word_valid_o;
  endproperty
  property p_wv_after_cs;
    word_valid_o |-> spi_cs_n_i && $past(spi_cs_n_i, 3);
  endproperty
  property p_err_set;
    $rose(frame_err_flag_o) |-> spi_cs_n_i && !word_valid_o;
  endproperty
  property p_err_clear;
    $fell(frame_err_flag_o) && !$past(soft_reset_i) |-> s_event_read;
  endproperty
  property p_oe_idle;
    s_cs_idle |-> !spi_miso_oe_o;
  endproperty
  property p_oe_active;
    s_cs_active |-> spi_miso_oe_o;
  endproperty
  property p_por_clear;
    $fell(por_flag_o) |-> s_event_read;
  endproperty
  property p_por_soft;
    soft_reset_i |=> por_flag_o && !frame_err_flag_o;
  endproperty
  property p_por_rise;
    $rose(por_flag_o) |-> $past(soft_reset_i);
  endproperty
  property p_word_hold;
    !word_valid_o && !$past(soft_reset_i) |-> $stable(word_o);
  endproperty

  a_header: assert property (p_header)
    else $error("header bit differs from power-up flag");
  a_wv_pulse: assert property (p_wv_pulse)
    else $error("word valid longer than one cycle");
  a_wv_after_cs: assert property (p_wv_after_cs)
    else $error("word valid before frame end");
  a_err_set: assert property (p_err_set)
    else $error("frame error set outside frame end");
  a_err_clear: assert property (p_err_clear)
    else $error("frame error cleared without event read");
  a_por_clear: assert property (p_por_clear)
    else $error("power-up flag cleared without event read");
  a_por_soft: assert property (p_por_soft)
    else $error("soft reset did not restore flags");
  a_por_rise: assert property (p_por_rise)
    else $error("power-up flag set without reset");
  a_word_hold: assert property (p_word_hold)
    else $error("word changed without valid");
  a_oe_idle: assert property (p_oe_idle)
    else $error("data out enabled while deselected");
  a_oe_active: assert property (p_oe_active)
    else $error("data out not enabled while selected");
endmodule : smsr_status_regs_chk

bind smsr_status_regs smsr_status_regs_chk i_chk (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .soft_reset_i(soft_reset_i),
  .spi_cs_n_i(spi_cs_n_i), .spi_sclk_i(spi_sclk_i), .spi_miso_o(spi_miso_o),
  .spi_miso_oe_o(spi_miso_oe_o),
  .word_valid_o(word_valid_o), .word_o(word_o),
  .frame_err_flag_o(frame_err_flag_o), .por_flag_o(por_flag_o));

// *** verif/test_switch_monitor_status_regs.sv ***
`timescale 1ns/1ns
module test_switch_monitor_status_regs;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic soft_reset_i = 1'b0;
  logic crc_valid_i = 1'b0;
  logic [15:0] crc_value_i = 16'h0000;
  logic [3:0] live = 4'h0;
  logic [23:0] comp_level_i = 24'h000000;
  logic go = 1'b0;
  logic [31:0] tx_word = 32'h0;
  logic [5:0] tx_bits = 6'h00;
  smsr_pkg::smsr_spi_pins_s pins;
  logic miso, busy, wv, err_f, por_f, por_m, err_m;
  logic [31:0] resp, word, r;
  logic [15:0] crc_m;
  logic [31:0] seed = 32'hCF3044BB;
  logic [31:0] rq[$];
  logic [31:0] wq[$];
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;

  smsr_status_regs i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .soft_reset_i(soft_reset_i), .spi_cs_n_i(pins.cs_n),
    .spi_sclk_i(pins.sclk), .spi_mosi_i(pins.mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(), .crc_value_i(crc_value_i), .crc_valid_i(crc_valid_i),
    .low_supply_now_i(live[3]), .high_supply_now_i(live[2]),
    .hot_warning_now_i(live[1]), .overheat_now_i(live[0]),
    .comp_level_i(comp_level_i), .word_valid_o(wv), .word_o(word),
    .frame_err_flag_o(err_f), .por_flag_o(por_f));
  smsr_host i_host (.clock_i(clock_i), .reset_n_i(reset_n_i), .go_i(go),
    .word_i(tx_word), .bits_i(tx_bits), .busy_o(busy), .resp_o(resp),
    .pins_o(pins), .miso_i(miso));

  initial begin
    forever #20 clock_i = ~clock_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [23:0] regval(logic [5:0] a);
    case (a)
      smsr_pkg::OFS_EVENT: return {22'h0, err_m, por_m};
      smsr_pkg::OFS_CRC: return {8'h00, crc_m};
      smsr_pkg::OFS_MISC: return {20'h0, live};
      smsr_pkg::OFS_COMP: return comp_level_i;
      default: return 24'h000000;
    endcase
  endfunction : regval

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic results();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic launch(logic [5:0] n, logic [31:0] f);
    @(posedge clock_i);
    tx_word <= f;
    tx_bits <= n;
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    @(posedge clock_i);
  endtask : launch

  task automatic send(logic [5:0] n, logic w, logic [5:0] a);
    logic [31:0] f;
    logic [31:0] x;
    x = rnd();
    f = {w, a, x[24:0]};
    if (n == smsr_pkg::FRAME_LEN) begin
      rq.push_back({por_m, err_m, 5'h00, regval(a), 1'b0});
      wq.push_back(f);
      if (!w && a == smsr_pkg::OFS_EVENT) {por_m, err_m} = 2'b00;
    end else if (n != 6'h00) err_m = 1'b1;
    launch(n, f);
    while (busy) @(posedge clock_i);
    repeat (8) @(posedge clock_i);
    // Flags settle one cycle after the frame end is seen
    @(negedge clock_i);
    check("error flag", {31'h0, err_m}, {31'h0, err_f});
    check("power-up flag", {31'h0, por_m}, {31'h0, por_f});
  endtask : send

  // Negative edge keeps sampling clear of the launching edge
  always @(negedge clock_i) begin
    if (wv === 1'b1) check("word", wq.size() ? wq.pop_front() : 'x, word);
  end
  always @(negedge busy) begin
    if (tx_bits == smsr_pkg::FRAME_LEN)
      check("response", rq.size() ? rq.pop_front() : 'x, resp);
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      results();
    end
  end

  task automatic defaults();
    por_m = 1'b1;
    err_m = 1'b0;
    crc_m = 16'hFFFF;
  endtask : defaults

  initial begin
    defaults();
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    send(6'h20, 1'b0, smsr_pkg::OFS_EVENT);
    send(6'h20, 1'b0, smsr_pkg::OFS_EVENT);
    send(6'h20, 1'b0, smsr_pkg::OFS_CRC);
    send(6'h00, 1'b0, smsr_pkg::OFS_EVENT);
    send(6'h1F, 1'b0, smsr_pkg::OFS_EVENT);
    send(6'h20, 1'b0, smsr_pkg::OFS_MISC);
    send(6'h20, 1'b0, smsr_pkg::OFS_EVENT);
    send(6'h21, 1'b0, smsr_pkg::OFS_EVENT);
    repeat (3) begin
      r = rnd();
      @(posedge clock_i);
      crc_value_i <= r[15:0];
      live <= r[19:16];
      comp_level_i <= r[31:8];
      crc_valid_i <= 1'b1;
      crc_m = r[15:0];
      @(posedge clock_i);
      crc_valid_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      for (int a = 1; a < 7; a++) begin
        send(6'h20, 1'b1, 6'(a));
        send(6'h20, 1'b0, 6'(a));
        send(6'h20, 1'b0, 6'(a));
      end
    end
    send(6'h1F, 1'b0, smsr_pkg::OFS_EVENT);
    @(posedge clock_i);
    soft_reset_i <= 1'b1;
    @(posedge clock_i);
    soft_reset_i <= 1'b0;
    defaults();
    send(6'h20, 1'b0, smsr_pkg::OFS_CRC);
    send(6'h20, 1'b0, smsr_pkg::OFS_EVENT);
    // Abort a frame by hardware reset; no word may appear
    launch(6'h1F, 32'h02000000);
    repeat (100) @(posedge clock_i);
    reset_n_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    defaults();
    repeat (8) @(posedge clock_i);
    send(6'h20, 1'b0, smsr_pkg::OFS_CRC);
    send(6'h20, 1'b0, smsr_pkg::OFS_EVENT);
    results();
  end
endmodule : test_switch_monitor_status_regs
